// file: inc/hid_regs_pkg.sv
package hid_regs_pkg;
  // register offsets on the mcu serial port
  localparam logic [3:0] IR0_OFS  = 4'h0;
  localparam logic [3:0] IR1_OFS  = 4'h1;
  localparam logic [3:0] IR2_OFS  = 4'h2;
  localparam logic [3:0] IR3_OFS  = 4'h3;
  localparam logic [3:0] OR0_OFS  = 4'h4;
  localparam logic [3:0] OR1_OFS  = 4'h5;
  localparam logic [3:0] OR2_OFS  = 4'h6;
  localparam logic [3:0] OR3_OFS  = 4'h7;
  localparam logic [3:0] CTRL_OFS = 4'h8;
  localparam logic [3:0] DLO_OFS  = 4'h9;
  localparam logic [3:0] DHI_OFS  = 4'ha;
  localparam logic [3:0] CMD_OFS  = 4'hb;
  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [3:0]  RST_PTR  = 4'h0;
  localparam logic [1:0]  RST_SYNC = 2'h0;
  // field positions
  localparam int MAP_BIT = 7;
  localparam int GO_BIT  = 7;
  localparam int DIR_BIT = 6;
  // fixed read values while mapped
  localparam logic [1:0] MAPPED_USAGE = 2'h3;
  localparam logic [3:0] MAPPED_LOW   = 4'h0;
  // mcu clock select codes
  typedef enum logic [1:0] {
    CLK_1M5 = 2'b00,
    CLK_3M  = 2'b01,
    CLK_6M  = 2'b10,
    CLK_RSV = 2'b11
  } mcu_clk_type;
endpackage

// file: core/hid_report_eeprom_regs.sv
`timescale 1ns/1ns
// Notes on behaviour
// - byte 2 generic, or high data when mapped
// - byte 3 generic, or command when mapped
// - mapped: out byte 0 bits 7-6 read 11
// - unmapped: out byte 0 shows host usage
// - mapped: out byte 0 bits 5-4 clock select
// - mapped: out byte 0 bits 3-0 read zero
// - mapped: out byte 1 reads low data
// - mapped: out byte 2 reads high data
// - mapped: out byte 3 reads command
// - out bytes read-only, else host values
// - control bits 5-4 pick mcu clock
// - low data byte, rw, resets zero
// - high data byte, rw, resets zero
// - command bit 7 reads pending flag
// - writing 1 launches access, self clears
// - command bit 6: 0 read, 1 write
// - command bits 5-0 give word address
// - in byte 0 bits 7-6 usage, 7 maps
// - irq on completion, cleared by report read
// - first byte is address, then auto-increment
module hid_report_eeprom_regs (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire logic                      mcuWrValid,
  input  wire logic                      mcuWrFirst,
  input  wire logic [7:0]                mcuWrData,
  input  wire logic                      mcuRdReq,
  output logic      [7:0]                mcuRdData,
  output logic                           mcuRdValid,
  input  wire logic                      hostWrValid,
  input  wire logic [1:0]                hostWrIndex,
  input  wire logic [7:0]                hostWrData,
  input  wire logic [3:0]                buttonStatus,
  output logic      [7:0]                inputReport0,
  output logic      [7:0]                inputReport1,
  output logic      [7:0]                inputReport2,
  output logic      [7:0]                inputReport3,
  output hid_regs_pkg::mcu_clk_type      mcuClkSel,
  output logic                           nvmStart,
  output logic                           nvmWrite,
  output logic      [5:0]                nvmWordAddr,
  output logic      [15:0]               nvmWrWord,
  input  wire logic                      nvmDone,
  input  wire logic [15:0]               nvmRdWord,
  output logic                           micro_interrupt_line
);
  import hid_regs_pkg::*;

  // reset release through two flops
  logic [1:0] rstSync_ff;
  logic       rstN;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync_ff <= RST_SYNC;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstN = rstSync_ff[1];

  // register state
  logic [7:4] ir0_ff,   nxt_ir0;    // usage and bits 5-4
  logic [7:0] ir1_ff,   nxt_ir1;
  logic [7:0] ir2_ff,   nxt_ir2;
  logic [7:0] ir3_ff,   nxt_ir3;
  logic [7:0] or0_ff,   nxt_or0;    // host programmed
  logic [7:0] or1_ff,   nxt_or1;
  logic [7:0] or2_ff,   nxt_or2;
  logic [7:0] or3_ff,   nxt_or3;
  logic [1:0] clk_ff,   nxt_clk;    // clock select
  logic [7:0] dLo_ff,   nxt_dLo;
  logic [7:0] dHi_ff,   nxt_dHi;
  logic [6:0] cmd_ff,   nxt_cmd;    // direction and address
  logic       pend_ff,  nxt_pend;
  logic       start_ff, nxt_start;
  logic       irq_ff,   nxt_irq;
  logic [3:0] ptr_ff,   nxt_ptr;
  logic [7:0] rd_ff,    nxt_rd;
  logic       rdv_ff,   nxt_rdv;
  logic       mapped;
  logic [7:0] rdByte;
  logic       wrData;

  assign mapped = ir0_ff[MAP_BIT];
  assign wrData = mcuWrValid && !mcuWrFirst;

  // read mux for the current pointer
  always_comb begin
    rdByte = RST_BYTE;
    unique case (ptr_ff)
      IR0_OFS: rdByte = {ir0_ff, buttonStatus};
      IR1_OFS: rdByte = mapped ? dLo_ff : ir1_ff;
      IR2_OFS: rdByte = mapped ? dHi_ff : ir2_ff;
      IR3_OFS: rdByte = mapped ? {pend_ff, cmd_ff}
                               : ir3_ff;
      OR0_OFS: begin
        if (mapped) begin
          // fixed usage, clock, zero nibble
          rdByte = {MAPPED_USAGE, clk_ff, MAPPED_LOW};
        end else begin
          rdByte = or0_ff;
        end
      end
      OR1_OFS: rdByte = mapped ? dLo_ff : or1_ff;
      OR2_OFS: rdByte = mapped ? dHi_ff : or2_ff;
      OR3_OFS: rdByte = mapped ? {pend_ff, cmd_ff}
                               : or3_ff;
      CTRL_OFS: rdByte = {2'h0, clk_ff, 4'h0};
      DLO_OFS: rdByte = dLo_ff;
      DHI_OFS: rdByte = dHi_ff;
      CMD_OFS: rdByte = {pend_ff, cmd_ff};
      default: rdByte = RST_BYTE;    // unmapped reads zero
    endcase
  end

  // next state of the whole bank
  always_comb begin
    nxt_ir0   = ir0_ff;
    nxt_ir1   = ir1_ff;
    nxt_ir2   = ir2_ff;
    nxt_ir3   = ir3_ff;
    nxt_or0   = or0_ff;
    nxt_or1   = or1_ff;
    nxt_or2   = or2_ff;
    nxt_or3   = or3_ff;
    nxt_clk   = clk_ff;
    nxt_dLo   = dLo_ff;
    nxt_dHi   = dHi_ff;
    nxt_cmd   = cmd_ff;
    nxt_pend  = pend_ff;
    nxt_start = 1'b0;
    nxt_irq   = irq_ff;
    nxt_ptr   = ptr_ff;
    nxt_rd    = rd_ff;
    nxt_rdv   = 1'b0;
    // pointer: first byte loads, later bytes step
    if (mcuWrValid && mcuWrFirst) begin
      nxt_ptr = mcuWrData[3:0];
    end else if (wrData || mcuRdReq) begin
      nxt_ptr = ptr_ff + 4'h1;
    end
    // read path, result held in a flop
    if (mcuRdReq) begin
      nxt_rd  = rdByte;
      nxt_rdv = 1'b1;
      // report read clears the line
      if (ptr_ff >= OR0_OFS && ptr_ff <= OR3_OFS) begin
        nxt_irq = 1'b0;
      end
    end
    // mcu writes; out bytes ignore them
    if (wrData) begin
      unique case (ptr_ff)
        IR0_OFS: begin
          nxt_ir0 = mcuWrData[7:4];
          if (mcuWrData[MAP_BIT]) begin
            nxt_clk = mcuWrData[5:4];
          end
        end
        IR1_OFS: begin
          nxt_ir1 = mcuWrData;
          if (mapped) begin
            nxt_dLo = mcuWrData;
          end
        end
        IR2_OFS: begin
          nxt_ir2 = mcuWrData;
          if (mapped) begin
            nxt_dHi = mcuWrData;
          end
        end
        IR3_OFS: begin
          nxt_ir3 = mcuWrData;
        end
        CTRL_OFS: nxt_clk = mcuWrData[5:4];
        DLO_OFS:  nxt_dLo = mcuWrData;
        DHI_OFS:  nxt_dHi = mcuWrData;
        default: ;
      endcase
      // command byte, direct or through byte 3
      if (ptr_ff == CMD_OFS || (ptr_ff == IR3_OFS && mapped)) begin
        nxt_cmd = mcuWrData[6:0];
        // a second launch while busy is dropped
        if (mcuWrData[GO_BIT] && !pend_ff) begin
          nxt_pend  = 1'b1;
          nxt_start = 1'b1;
        end
      end
    end
    // host updates of the output report
    if (hostWrValid) begin
      unique case (hostWrIndex)
        2'h0: nxt_or0 = hostWrData;
        2'h1: nxt_or1 = hostWrData;
        2'h2: nxt_or2 = hostWrData;
        2'h3: nxt_or3 = hostWrData;
      endcase
      nxt_irq = 1'b1;    // set wins over a clearing read
    end
    // completion: read data loads in the same cycle the flag drops
    if (nvmDone && pend_ff) begin
      if (!cmd_ff[DIR_BIT]) begin
        nxt_dLo = nvmRdWord[7:0];
        nxt_dHi = nvmRdWord[15:8];
      end
      nxt_pend = 1'b0;
      nxt_irq  = 1'b1;
    end
  end

  // state flops, all zero on reset
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ir0_ff   <= RST_BYTE[7:4];
      ir1_ff   <= RST_BYTE;
      ir2_ff   <= RST_BYTE;
      ir3_ff   <= RST_BYTE;
      or0_ff   <= RST_BYTE;
      or1_ff   <= RST_BYTE;
      or2_ff   <= RST_BYTE;
      or3_ff   <= RST_BYTE;
      clk_ff   <= CLK_1M5;
      dLo_ff   <= RST_BYTE;
      dHi_ff   <= RST_BYTE;
      cmd_ff   <= RST_BYTE[6:0];
      pend_ff  <= 1'b0;
      start_ff <= 1'b0;
      irq_ff   <= 1'b0;
      ptr_ff   <= RST_PTR;
      rd_ff    <= RST_BYTE;
      rdv_ff   <= 1'b0;
    end else begin
      ir0_ff   <= nxt_ir0;
      ir1_ff   <= nxt_ir1;
      ir2_ff   <= nxt_ir2;
      ir3_ff   <= nxt_ir3;
      or0_ff   <= nxt_or0;
      or1_ff   <= nxt_or1;
      or2_ff   <= nxt_or2;
      or3_ff   <= nxt_or3;
      clk_ff   <= nxt_clk;
      dLo_ff   <= nxt_dLo;
      dHi_ff   <= nxt_dHi;
      cmd_ff   <= nxt_cmd;
      pend_ff  <= nxt_pend;
      start_ff <= nxt_start;
      irq_ff   <= nxt_irq;
      ptr_ff   <= nxt_ptr;
      rd_ff    <= nxt_rd;
      rdv_ff   <= nxt_rdv;
    end
  end

  // outputs straight from flops, except the button nibble of input byte 0
  assign mcuRdData    = rd_ff;
  assign mcuRdValid   = rdv_ff;
  assign inputReport0 = {ir0_ff, buttonStatus};
  assign inputReport1 = ir1_ff;
  assign inputReport2 = ir2_ff;
  assign inputReport3 = ir3_ff;
  assign mcuClkSel    = mcu_clk_type'(clk_ff);
  assign nvmStart     = start_ff;
  assign nvmWrite     = cmd_ff[DIR_BIT];
  assign nvmWordAddr  = cmd_ff[5:0];
  assign nvmWrWord    = {dHi_ff, dLo_ff};
  assign micro_interrupt_line = irq_ff;

  // checks
  logic launch;
  assign launch = nxt_start;

  sequence s_launch;
    launch;
  endsequence
  sequence s_started;
    nvmStart && pend_ff;
  endsequence

  property p_launch;
    @(posedge core_clk) disable iff (!rstN)
      s_launch |=> s_started;
  endproperty
  a_launch: assert property (p_launch) else $error("no start");

  property p_done;
    @(posedge core_clk) disable iff (!rstN)
      (nvmDone && pend_ff) |=> (!pend_ff && irq_ff);
  endproperty
  a_done: assert property (p_done) else $error("done lost");

  property p_rdload;
    @(posedge core_clk) disable iff (!rstN)
      (nvmDone && pend_ff && !nvmWrite)
        |=> ({dHi_ff, dLo_ff} == $past(nvmRdWord));
  endproperty
  a_rdload: assert property (p_rdload) else $error("data not loaded");

  property p_or0map;
    @(posedge core_clk) disable iff (!rstN)
      (mcuRdReq && ptr_ff == OR0_OFS && mapped)
        |=> (mcuRdData == {2'b11, clk_ff, 4'h0});
  endproperty
  a_or0map: assert property (p_or0map) else $error("or0 mapped bad");

  property p_or1map;
    @(posedge core_clk) disable iff (!rstN)
      (mcuRdReq && ptr_ff == OR1_OFS && mapped && !nvmDone)
        |=> (mcuRdValid && mcuRdData == dLo_ff);
  endproperty
  a_or1map: assert property (p_or1map) else $error("or1 mapped bad");

  property p_autoinc;
    @(posedge core_clk) disable iff (!rstN)
      (mcuRdReq && !mcuWrValid) |=> (ptr_ff == $past(ptr_ff) + 4'h1);
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("no increment");

  property p_irqclr;
    @(posedge core_clk) disable iff (!rstN)
      (mcuRdReq && ptr_ff[3:2] == 2'b01 && !hostWrValid && !nvmDone)
        |=> !micro_interrupt_line;
  endproperty
  a_irqclr: assert property (p_irqclr) else $error("irq not cleared");

  property p_startonly;
    @(posedge core_clk) disable iff (!rstN)
      nvmStart |-> $past(launch) ##1 !nvmStart;
  endproperty
  a_startonly: assert property (p_startonly) else $error("stray start");

endmodule

// file: bench/nvm_engine_model.sv
`timescale 1ns/1ns
// serial eeprom engine: answers each launch after lat idle cycles
module nvm_engine_model (
  input  wire logic        core_clk,
  input  wire logic        nvmStart,
  input  wire logic        nvmWrite,
  input  wire logic [5:0]  nvmWordAddr,
  input  wire logic [15:0] nvmWrWord,
  input  wire logic [7:0]  lat,
  output logic             nvmDone,
  output logic [15:0]      nvmRdWord,
  output logic             busy,
  output logic             lastWrite,
  output logic [5:0]       lastAddr,
  output logic [15:0]      lastWord,
  output int               starts
);
  logic [15:0] mem [64]; // word store
  int          cnt;      // cycles left in access
  initial begin
    nvmDone = 1'b0;
    nvmRdWord = 16'ha5c3;
    busy = 1'b0;
    starts = 0;
    foreach (mem[i]) mem[i] = 16'hc3a5 ^ 16'(i);
  end
  // one access at a time; read word only valid with done
  always @(posedge core_clk) begin
    nvmDone <= 1'b0;
    nvmRdWord <= ~nvmRdWord; // bus released: keep it moving
    if (nvmStart) begin
      busy <= 1'b1;
      cnt <= int'(lat);
      starts <= starts + 1;
      lastWrite <= nvmWrite;
      lastAddr <= nvmWordAddr;
      lastWord <= nvmWrWord;
    end else if (busy && cnt > 0) begin
      cnt <= cnt - 1;
    end else if (busy) begin
      busy <= 1'b0;
      nvmDone <= 1'b1;
      nvmRdWord <= mem[lastAddr];
      if (lastWrite) mem[lastAddr] <= lastWord;
    end
  end
endmodule

// file: bench/test_hid_report_eeprom_regs.sv
`timescale 1ns/1ns
module test_hid_report_eeprom_regs;
  import hid_regs_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        mcuWrValid = 1'b0;  // mcu serial side
  logic        mcuWrFirst = 1'b0;
  logic [7:0]  mcuWrData = 8'h00;
  logic        mcuRdReq = 1'b0;
  logic [7:0]  mcuRdData;
  logic        mcuRdValid;
  logic        hostWrValid = 1'b0; // usb host side
  logic [1:0]  hostWrIndex = 2'h0;
  logic [7:0]  hostWrData = 8'h00;
  logic [3:0]  buttonStatus = 4'h0;
  logic [7:0]  inputReport0, inputReport1, inputReport2, inputReport3;
  mcu_clk_type mcuClkSel;
  logic        nvmStart, nvmWrite, nvmDone, irq, busy, lastWrite;
  logic [5:0]  nvmWordAddr, lastAddr, a;
  logic [15:0] nvmWrWord, nvmRdWord, lastWord, w;
  logic [7:0]  lat = 8'h06;        // engine latency, varied per word, shared by its write and read
  logic [7:0]  v;
  logic [7:0]  b [4];              // host report bytes
  logic [31:0] seed = 32'hcf77_aab2;
  int          starts, s0, n_mismatch = 0, check_count = 0, cyc = 0;

  hid_report_eeprom_regs i_dut (.core_clk(core_clk), .nrst(nrst), .mcuWrValid(mcuWrValid),
    .mcuWrFirst(mcuWrFirst), .mcuWrData(mcuWrData), .mcuRdReq(mcuRdReq),
    .mcuRdData(mcuRdData), .mcuRdValid(mcuRdValid), .hostWrValid(hostWrValid),
    .hostWrIndex(hostWrIndex), .hostWrData(hostWrData), .buttonStatus(buttonStatus),
    .inputReport0(inputReport0), .inputReport1(inputReport1), .inputReport2(inputReport2),
    .inputReport3(inputReport3), .mcuClkSel(mcuClkSel), .nvmStart(nvmStart),
    .nvmWrite(nvmWrite), .nvmWordAddr(nvmWordAddr), .nvmWrWord(nvmWrWord),
    .nvmDone(nvmDone), .nvmRdWord(nvmRdWord), .micro_interrupt_line(irq));
  nvm_engine_model i_nvm (.core_clk(core_clk), .nvmStart(nvmStart), .nvmWrite(nvmWrite),
    .nvmWordAddr(nvmWordAddr), .nvmWrWord(nvmWrWord), .lat(lat), .nvmDone(nvmDone),
    .nvmRdWord(nvmRdWord), .busy(busy), .lastWrite(lastWrite), .lastAddr(lastAddr),
    .lastWord(lastWord), .starts(starts));

  initial forever #20 core_clk = ~core_clk;
  // hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      summarize();
    end
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // mapped view of output byte 0
  function automatic logic [7:0] or0Exp(input logic [1:0] c);
    return {MAPPED_USAGE, c, MAPPED_LOW};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // first byte of a frame sets the pointer
  task automatic ptr(input logic [3:0] ad);
    @(negedge core_clk);
    mcuWrValid = 1'b1;
    mcuWrFirst = 1'b1;
    mcuWrData = {4'h0, ad};
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    ptr(ad);
    @(negedge core_clk);
    mcuWrFirst = 1'b0;
    mcuWrData = d;
    @(negedge core_clk);
    mcuWrValid = 1'b0;
  endtask
  task automatic chkrd(input logic [3:0] ad, input logic [7:0] e);
    ptr(ad);
    @(negedge core_clk);
    mcuWrValid = 1'b0;
    mcuRdReq = 1'b1;
    @(negedge core_clk);
    mcuRdReq = 1'b0;
    chk("read strobe", 16'h0001, {15'h0, mcuRdValid});
    chk($sformatf("register %h", ad), {8'h00, e}, {8'h00, mcuRdData});
  endtask
  task automatic hw(input logic [1:0] i, input logic [7:0] d);
    @(negedge core_clk);
    hostWrValid = 1'b1;
    hostWrIndex = i;
    hostWrData = d;
    @(negedge core_clk);
    hostWrValid = 1'b0;
  endtask
  // bounded wait for the engine to finish
  task automatic idle();
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < 300 && busy === 1'b1; i++) @(negedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    buttonStatus = 4'(rnd());
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    // reset image, unmapped offset 0xc included
    for (int r = 0; r < 13; r++) chkrd(4'(r), r == 0 ? {4'h0, buttonStatus} : 8'h00);
    chk("clock select", 16'(CLK_1M5), 16'(mcuClkSel));
    wr(IR0_OFS, 8'h40);
    chk("input byte 0", {8'h00, 4'h4, buttonStatus}, {8'h00, inputReport0});
    s0 = starts;
    v = 8'(rnd());
    wr(IR2_OFS, v);
    chk("input byte 2", {8'h00, v}, {8'h00, inputReport2});
    // generic byte 1 while unmapped
    wr(IR1_OFS, ~v);
    chk("input byte 1", {8'h00, ~v}, {8'h00, inputReport1});
    wr(IR3_OFS, 8'hff);
    chk("input byte 3", 16'h00ff, {8'h00, inputReport3});
    chk("unmapped launch", 16'(s0), 16'(starts));
    // host report bytes with every usage code
    for (int u = 0; u < 4; u++) begin
      foreach (b[k]) b[k] = 8'(rnd());
      b[0][7:6] = 2'(u);
      foreach (b[k]) hw(2'(k), b[k]);
      @(negedge core_clk);
      chk("irq after host write", 16'h0001, {15'h0, irq});
      foreach (b[k]) chkrd(OR0_OFS + 4'(k), b[k]);
      chk("irq after read", 16'h0000, {15'h0, irq});
    end
    wr(OR1_OFS, ~b[1]);
    chkrd(OR1_OFS, b[1]);
    // mapped mode, each legal clock code
    for (int c = 0; c < 3; c++) begin
      wr(IR0_OFS, {2'b10, 2'(c), 4'hf});
      chk("clock select", 16'(c), 16'(mcuClkSel));
      chk("button nibble", {12'h0, buttonStatus}, {12'h0, inputReport0[3:0]});
      chkrd(OR0_OFS, or0Exp(2'(c)));
      chkrd(CTRL_OFS, {2'b00, 2'(c), 4'h0});
    end
    // write a word, then read it back into cleared data registers
    for (int t = 0; t < 4; t++) begin
      w = 16'(rnd());
      a = 6'(rnd());
      lat = 8'(6 + rnd() % 8);
      // low byte direct or through mapped byte 1
      wr(t[0] ? IR1_OFS : DLO_OFS, w[7:0]);
      wr(IR2_OFS, w[15:8]);
      chkrd(OR1_OFS, w[7:0]);
      chkrd(OR2_OFS, w[15:8]);
      s0 = starts;
      wr(IR3_OFS, {2'b11, a});
      wr(CMD_OFS, {2'b11, a});
      chkrd(t[1] ? IR3_OFS : CMD_OFS, {2'b11, a});
      chk("launch count", 16'(s0 + 1), 16'(starts));
      chk("access kind", {9'h0, 1'b1, a}, {9'h0, lastWrite, lastAddr});
      chk("write word", w, lastWord);
      idle();
      chk("irq on completion", 16'h0001, {15'h0, irq});
      chkrd(OR3_OFS, {2'b01, a});
      wr(DLO_OFS, 8'h00);
      wr(DHI_OFS, 8'h00);
      // mapped byte 2 shows the cleared high byte, not its own copy
      chkrd(IR2_OFS, 8'h00);
      wr(CMD_OFS, {2'b10, a});
      idle();
      chk("read kind", 16'h0000, {15'h0, lastWrite});
      chkrd(DLO_OFS, w[7:0]);
      chkrd(DHI_OFS, w[15:8]);
    end
    summarize();
  end
endmodule
